// >>> hdl/asp_defines.svh
// Timing and geometry constants for the static memory port controller.
// Assumes a 50 MHz system clock; included by the package and the controller.
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

`define ASP_CLK_PERIOD_PS 20000
`define ASP_ADDR_BITS 15
`define ASP_DATA_BITS 8
`define ASP_WORDS 32768

// Minimum times in picoseconds
`define ASP_T_RC_PS 15000
`define ASP_T_AA_PS 15000
`define ASP_T_OHZ_PS 7000
`define ASP_T_WC_PS 15000
`define ASP_T_WP_PS 10000
`define ASP_T_AW_PS 12000
`define ASP_T_DW_PS 8000
`define ASP_T_WHZ_PS 8000
`define ASP_T_OW_PS 4000
`define ASP_T_RECOVER_PS 15000

// Cycle counts, least times rounded up, never below one
`define ASP_CYC(ps) ((((ps) + `ASP_CLK_PERIOD_PS - 1) / `ASP_CLK_PERIOD_PS) < 1 ? 1 : \
  (((ps) + `ASP_CLK_PERIOD_PS - 1) / `ASP_CLK_PERIOD_PS))
`define ASP_RD_CYC `ASP_CYC(`ASP_T_AA_PS)
`define ASP_RD_GAP_CYC `ASP_CYC(`ASP_T_OHZ_PS)
`define ASP_WR_PULSE_CYC `ASP_CYC(`ASP_T_WHZ_PS + `ASP_T_DW_PS)
`define ASP_WR_SETUP_CYC `ASP_CYC(`ASP_T_WHZ_PS)
`define ASP_RECOVER_CYC `ASP_CYC(`ASP_T_RECOVER_PS)

`endif

// >>> hdl/asp_pkg.sv
// Types shared by the static memory port controller.
// Assumes asp_defines.svh is on the include path.
`include "asp_defines.svh"

package asp_pkg;
  typedef struct packed {
    logic write;
    logic [`ASP_ADDR_BITS-1:0] addr;
    logic [`ASP_DATA_BITS-1:0] wdata;
  } asp_req_t;

  typedef struct packed {
    logic chip_select_n;
    logic write_strobe_n;
    logic output_drive_n;
    logic [`ASP_ADDR_BITS-1:0] word_address;
  } asp_pins_t;

  typedef enum logic [2:0] {
    ASP_IDLE, ASP_RD_ACCESS, ASP_RD_RELEASE, ASP_WR_SETUP, ASP_WR_PULSE,
    ASP_WR_END, ASP_RETAIN, ASP_RECOVER
  } asp_state_t;
endpackage

// >>> hdl/asp_ctrl.sv
// Host-side controller for a 32K x 8 asynchronous static memory.
// Assumes the memory pins are sampled/driven on clk; data pin wire resolved outside.
`timescale 1ns/1ps

`include "asp_defines.svh"

// Summary of operation
// - The host keeps write_strobe_n high throughout every read.
// - The host sets a valid address no later than the falling edge of chip_select_n for a read.
// - A strobe-timed write with output_drive_n low needs a pulse longer than turn-off delay plus data setup.
// - The host never drives data while the memory may still be driving the lines.
// - For retention the host deselects before supply drop and waits one read cycle after recovery.
module asp_ctrl #(
  parameter int ADDR_BITS = `ASP_ADDR_BITS,
  parameter int DATA_BITS = `ASP_DATA_BITS
) (
  input wire logic clk,
  input wire logic reset,
  // Request side
  input wire asp_pkg::asp_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  output logic [DATA_BITS-1:0] rdata,
  output logic rdata_valid,
  // Supply retention control
  input wire logic retain_req,
  // Memory pins
  output asp_pkg::asp_pins_t pins,
  input wire logic [DATA_BITS-1:0] shared_data_lines_in,
  output logic [DATA_BITS-1:0] shared_data_lines_out,
  output logic shared_data_lines_oe_n
);

  // Pin structs are fixed to the memory geometry, so other widths cannot be served
  if (ADDR_BITS != `ASP_ADDR_BITS || DATA_BITS != `ASP_DATA_BITS) begin : g_bad_width
    $error("asp_ctrl: widths must match the memory geometry");
  end

  localparam logic [3:0] RD_CYC = 4'(`ASP_RD_CYC);
  localparam logic [3:0] RD_GAP_CYC = 4'(`ASP_RD_GAP_CYC);
  localparam logic [3:0] WR_PULSE_CYC = 4'(`ASP_WR_PULSE_CYC);
  localparam logic [3:0] WR_SETUP_CYC = 4'(`ASP_WR_SETUP_CYC);
  localparam logic [3:0] RECOVER_CYC = 4'(`ASP_RECOVER_CYC);

  // ****************************************
  // Sequencer
  // ****************************************
  asp_pkg::asp_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  asp_pkg::asp_pins_t pins_q, pins_d;
  logic [DATA_BITS-1:0] wdata_q, wdata_d;
  logic oe_n_q, oe_n_d;
  logic [DATA_BITS-1:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic ready_q, ready_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    pins_d = pins_q;
    wdata_d = wdata_q;
    oe_n_d = oe_n_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    ready_d = 1'b0;
    case (state_q)
      asp_pkg::ASP_IDLE: begin
        pins_d.chip_select_n = 1'b1;
        pins_d.write_strobe_n = 1'b1;
        pins_d.output_drive_n = 1'b1;
        oe_n_d = 1'b1;
        if (retain_req) begin
          state_d = asp_pkg::ASP_RETAIN;
        end else if (req_valid && ready_q) begin
          // Address settles in the same edge the select falls
          pins_d.word_address = req.addr;
          pins_d.chip_select_n = 1'b0;
          wdata_d = req.wdata;
          if (req.write) begin
            // Output drive stays high so the memory never drives during a write
            pins_d.write_strobe_n = 1'b0;
            cnt_d = WR_SETUP_CYC;
            state_d = asp_pkg::ASP_WR_SETUP;
          end else begin
            pins_d.output_drive_n = 1'b0;
            cnt_d = RD_CYC;
            state_d = asp_pkg::ASP_RD_ACCESS;
          end
        end else begin
          ready_d = 1'b1;
        end
      end
      asp_pkg::ASP_RD_ACCESS: begin
        // Strobe held high for the whole read
        if (cnt_q == 4'h1) begin
          rdata_d = shared_data_lines_in;
          rvalid_d = 1'b1;
          pins_d.chip_select_n = 1'b1;
          pins_d.output_drive_n = 1'b1;
          cnt_d = RD_GAP_CYC;
          state_d = asp_pkg::ASP_RD_RELEASE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      asp_pkg::ASP_RD_RELEASE: begin
        // Wait out the memory's turn-off before anything else may drive
        if (cnt_q == 4'h1) begin
          ready_d = !retain_req;
          state_d = asp_pkg::ASP_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      asp_pkg::ASP_WR_SETUP: begin
        // Bus kept released for a turn-off delay before write data goes out
        if (cnt_q == 4'h1) begin
          oe_n_d = 1'b0;
          cnt_d = WR_PULSE_CYC;
          state_d = asp_pkg::ASP_WR_PULSE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      asp_pkg::ASP_WR_PULSE: begin
        if (cnt_q == 4'h1) begin
          pins_d.write_strobe_n = 1'b1;
          state_d = asp_pkg::ASP_WR_END;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      asp_pkg::ASP_WR_END: begin
        // Data held one cycle past the strobe rise, then released
        pins_d.chip_select_n = 1'b1;
        oe_n_d = 1'b1;
        ready_d = !retain_req;
        state_d = asp_pkg::ASP_IDLE;
      end
      asp_pkg::ASP_RETAIN: begin
        // Chip stays deselected while the supply is low
        pins_d.chip_select_n = 1'b1;
        if (!retain_req) begin
          cnt_d = RECOVER_CYC;
          state_d = asp_pkg::ASP_RECOVER;
        end
      end
      asp_pkg::ASP_RECOVER: begin
        if (cnt_q == 4'h1) begin
          ready_d = 1'b1;
          state_d = asp_pkg::ASP_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: begin
        state_d = asp_pkg::ASP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= asp_pkg::ASP_IDLE;
      cnt_q <= 4'h0;
      pins_q <= {1'b1, 1'b1, 1'b1, {ADDR_BITS{1'b0}}};
      wdata_q <= '0;
      oe_n_q <= 1'b1;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pins_q <= pins_d;
      wdata_q <= wdata_d;
      oe_n_q <= oe_n_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      ready_q <= ready_d;
    end
  end

  assign pins = pins_q;
  assign shared_data_lines_out = wdata_q;
  assign shared_data_lines_oe_n = oe_n_q;
  assign rdata = rdata_q;
  assign rdata_valid = rvalid_q;
  assign req_ready = ready_q;

  // ****************************************
  // Checks
  // ****************************************
  a_read_strobe_high: assert property (@(posedge clk) disable iff (reset)
    !pins_q.output_drive_n |-> pins_q.write_strobe_n)
    else $error("write strobe low during read");
  a_no_bus_fight: assert property (@(posedge clk) disable iff (reset)
    !oe_n_q |-> pins_q.output_drive_n && $past(pins_q.output_drive_n))
    else $error("host drives while memory may drive");
  a_wr_pulse_len: assert property (@(posedge clk) disable iff (reset)
    $fell(pins_q.write_strobe_n) |-> !pins_q.write_strobe_n [*2])
    else $error("write pulse too short");
  a_write_in_select: assert property (@(posedge clk) disable iff (reset)
    !pins_q.write_strobe_n |-> !pins_q.chip_select_n)
    else $error("strobe low while deselected");
  a_read_access_time: assert property (@(posedge clk) disable iff (reset)
    $fell(pins_q.output_drive_n) |-> !pins_q.chip_select_n ##1
      (rvalid_q && pins_q.output_drive_n))
    else $error("read access shorter than access time");
  a_addr_stable: assert property (@(posedge clk) disable iff (reset)
    !pins_q.chip_select_n && !$past(pins_q.chip_select_n) |->
      $stable(pins_q.word_address))
    else $error("address moved during access");
  a_retain_desel: assert property (@(posedge clk) disable iff (reset)
    state_q == asp_pkg::ASP_RETAIN |-> pins_q.chip_select_n)
    else $error("selected during retention");
  a_data_hold: assert property (@(posedge clk) disable iff (reset)
    $rose(pins_q.write_strobe_n) |-> !oe_n_q)
    else $error("write data released before strobe end");

  c_read: cover property (@(posedge clk) disable iff (reset) rvalid_q);
  c_write: cover property (@(posedge clk) disable iff (reset) $rose(pins_q.write_strobe_n));
  c_retain: cover property (@(posedge clk) disable iff (reset) state_q == asp_pkg::ASP_RECOVER);
endmodule

// >>> verif/asp_mem_model.sv
// Behavioural 32K x 8 static memory facing the controller pins.
// Assumes the bench resolves the shared data lines from the host enable alone.
`timescale 1ns/1ps
module asp_mem_model (
  // Memory pins
  input wire asp_pkg::asp_pins_t pins,
  input wire logic [7:0] data_in,
  // Read side of the shared lines
  output logic [7:0] data_out,
  output logic drive
);
  logic [7:0] mem [0:32767];
  logic [7:0] last_q = 8'h00;
  logic wr;
  // Strobe low keeps outputs off, so a strobe-led write never drives
  assign drive = !pins.chip_select_n && pins.write_strobe_n
    && !pins.output_drive_n;
  assign wr = !pins.chip_select_n && !pins.write_strobe_n;
  always @(pins or drive) if (drive) last_q = mem[pins.word_address];
  // Released lines show the inverse of the last word, never a stale match
  assign data_out = drive ? mem[pins.word_address] : ~last_q;
  always @(negedge wr) mem[pins.word_address] = data_in;
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the static memory port controller.
// Assumes asp_mem_model stands on the memory pins.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  asp_pkg::asp_req_t req = '0;
  logic req_valid = 1'b0;
  logic retain_req = 1'b0;
  logic req_ready, rdata_valid, oe_n, mem_drive;
  logic [7:0] rdata, host_out, mem_out, bus;
  asp_pkg::asp_pins_t pins;
  int n_mismatch = 0;
  int checks = 0;
  always #10 clk = ~clk;
  assign bus = !oe_n ? host_out : mem_out;
  asp_ctrl u_dut (.clk(clk), .reset(reset), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid),
    .retain_req(retain_req), .pins(pins), .shared_data_lines_in(bus),
    .shared_data_lines_out(host_out), .shared_data_lines_oe_n(oe_n));
  asp_mem_model u_mem (.pins(pins), .data_in(bus), .data_out(mem_out), .drive(mem_drive));
  task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic access(input logic wr, input logic [14:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    check("ready", req_ready, 1'b1);
    req = '{write: wr, addr: a, wdata: d};
    req_valid = 1'b1;
    tick(1);
    req_valid = 1'b0;
    check("address", {pins.chip_select_n, pins.word_address}, {1'b0, a});
  endtask
  task automatic read_chk(input logic [14:0] a, input logic [7:0] exp);
    int n;
    access(1'b0, a, 8'h00);
    n = 0;
    while (rdata_valid !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    check("rdata", {rdata_valid, rdata}, {1'b1, exp});
  endtask
  // Contention and read-strobe watch on every rising clock edge outside reset
  always @(posedge clk) if (!reset) begin
    if (!oe_n) check("contention", mem_drive, 1'b0);
    if (!pins.output_drive_n) check("rd strobe", pins.write_strobe_n, 1'b1);
  end
  task automatic test_reset();
    check("rst pins", {pins.chip_select_n, pins.write_strobe_n, pins.output_drive_n,
      oe_n, req_ready}, 5'b11110);
    reset = 1'b0;
    tick(2);
    check("ready", req_ready, 1'b1);
    $display("test reset done");
  endtask
  task automatic test_rw();
    logic [14:0] ad [4];
    logic [7:0] dt [4];
    ad = '{15'h0000, 15'h7FFF, 15'h5555, 15'h2AAA};
    dt = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
    for (int i = 0; i < 4; i++) access(1'b1, ad[i], dt[i]);
    for (int i = 0; i < 4; i++) read_chk(ad[i], dt[i]);
    access(1'b1, 15'h0000, 8'h3C);
    read_chk(15'h0000, 8'h3C);
    read_chk(15'h7FFF, 8'h5A);
    $display("test rw done");
  endtask
  task automatic test_retain();
    retain_req = 1'b1;
    req = '{write: 1'b1, addr: 15'h0000, wdata: 8'h99};
    req_valid = 1'b1;
    tick(4);
    check("retain cs", {pins.chip_select_n, req_ready}, 2'b10);
    req_valid = 1'b0;
    retain_req = 1'b0;
    tick(1);
    check("recover", req_ready, 1'b0);
    read_chk(15'h0000, 8'h3C);
    $display("test retain done");
  endtask
  initial begin
    tick(5);
    test_reset();
    test_rw();
    test_retain();
    complete_run();
  end
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
endmodule
